// File: logic/fsp_ctrl_end.sv
// Purpose: Controller end: issues mode register commands from AXI4-Lite
// Assumes: ck is made here by dividing aclk; cs changes one aclk cycle after its fall, mrw, ma and op at command start
// Notes: Busy commands are dropped; status shows busy and read data
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl_end (
	input wire logic aclk,
	input wire logic aresetn,
	fsp_link_if.ctrl link,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fsp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [fsp_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	typedef enum logic [2:0] {
		FSP_IDLE = 3'b001,
		FSP_SEND = 3'b010,
		FSP_WAIT = 3'b100
	} fsp_state_t;

	fsp_state_t state_q;
	logic [2:0] div_q;
	logic ck_q;
	logic fall_en;
	logic aw_have_q;
	logic w_have_q;
	logic [fsp_pkg::ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_do;
	logic start;
	fsp_pkg::fsp_cmd_t req;
	logic [7:0] op_eff;
	logic is_switch;
	logic cs_q;
	logic mrw_q;
	logic [5:0] ma_q;
	logic [7:0] op_q;
	logic [fsp_pkg::CNT_W-1:0] wait_q;
	logic [fsp_pkg::CNT_W-1:0] wait_set;
	logic [7:0] rd_s1_q;
	logic [7:0] rd_s2_q;
	logic [7:0] rd_data_q;
	fsp_pkg::fsp_set_point_select_ctrl_t sel_sh_q;
	logic [1:0][7:0] vref_sh_q;

	// Link clock divider, free running so the clock always stays valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 3'h0;
			ck_q <= 1'b0;
		end else begin
			div_q <= div_q + 1'b1;
			ck_q <= (div_q == fsp_pkg::CK_LAST) || (div_q < 3'(fsp_pkg::CK_HALF - 1)); // R18 R19
		end
	end

	assign fall_en = (div_q == fsp_pkg::CK_FALL);

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign wr_do = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_do) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fsp_pkg::RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == fsp_pkg::OFS_CMD || aw_addr_q == fsp_pkg::OFS_STATUS) ?
				fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fsp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fsp_pkg::RESP_OKAY;
			if (s_axi_araddr == fsp_pkg::OFS_STATUS) begin
				s_axi_rdata <= {8'h00, sel_sh_q, rd_data_q, 7'h00, (state_q != FSP_IDLE)};
			end else if (s_axi_araddr != fsp_pkg::OFS_CMD) begin
				s_axi_rresp <= fsp_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Command decode; a set-point change forces fast reference mode
	assign req = fsp_pkg::fsp_cmd_t'(w_data_q);
	assign start = wr_do && (aw_addr_q == fsp_pkg::OFS_CMD) && (w_strb_q == fsp_pkg::STRB_ALL) &&
		(state_q == FSP_IDLE);
	assign is_switch = !req.mrr && (req.ma == fsp_pkg::MA_SELECT) &&
		(req.op[7] != sel_sh_q.setpoint_operating_select);
	assign op_eff = is_switch ? (req.op | 8'(fsp_fast_mask())) : req.op; // R14 R21

	function automatic fsp_pkg::fsp_set_point_select_ctrl_t fsp_fast_mask();
		fsp_pkg::fsp_set_point_select_ctrl_t m;
		m = '0;
		m.reference_generator_current_mode = 1'b1;
		return m;
	endfunction

	always_comb begin
		if (req.mrr) begin
			wait_set = fsp_pkg::CNT_W'(fsp_pkg::RD_WAIT_CYC);
		end else if (is_switch) begin
			// Same selection either way round
			wait_set = fsp_pkg::fsp_switch_cycles(vref_sh_q[0], vref_sh_q[1]) +
				fsp_pkg::CNT_W'(fsp_pkg::CLK_HOLD_CYC); // R15 R16 R17 R20 R22
		end else begin
			wait_set = fsp_pkg::CNT_W'(fsp_pkg::CMD_GAP_CYC);
		end
	end

	// Shadow of select bits as sent, fast reference bit included, and reference copies as written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_sh_q <= fsp_pkg::fsp_set_point_select_ctrl_t'(fsp_pkg::SELECT_RESET);
			vref_sh_q <= {fsp_pkg::DUP_RESET, fsp_pkg::DUP_RESET};
		end else if (start && !req.mrr) begin
			if (req.ma == fsp_pkg::MA_SELECT) begin
				sel_sh_q <= fsp_pkg::fsp_set_point_select_ctrl_t'(op_eff);
			end
			if (req.ma == fsp_pkg::DUP_MA[fsp_pkg::IDX_CMD_ADDR_REFERENCE_CFG]) begin
				vref_sh_q[sel_sh_q.setpoint_access_select] <= req.op;
			end
		end
	end

	// Command sequencer; only deselect while waiting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= FSP_IDLE;
			cs_q <= 1'b0;
			mrw_q <= 1'b0;
			ma_q <= 6'h00;
			op_q <= 8'h00;
			wait_q <= '0;
		end else begin
			unique case (state_q)
				FSP_IDLE: begin
					if (start) begin
						state_q <= FSP_SEND;
						mrw_q <= !req.mrr;
						ma_q <= req.ma;
						op_q <= op_eff;
						wait_q <= wait_set;
					end
				end
				FSP_SEND: begin
					if (fall_en) begin
						cs_q <= !cs_q;
						if (cs_q) begin
							state_q <= FSP_WAIT; // R22
						end
					end
				end
				FSP_WAIT: begin
					wait_q <= wait_q - 1'b1;
					if (wait_q == fsp_pkg::CNT_W'(1)) begin
						state_q <= FSP_IDLE;
					end
				end
			endcase
		end
	end

	// Read data held by the far end; synchronised, caught at the end of the wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_s1_q <= 8'h00;
			rd_s2_q <= 8'h00;
			rd_data_q <= 8'h00;
		end else begin
			rd_s1_q <= link.mrr_data;
			rd_s2_q <= rd_s1_q;
			if (state_q == FSP_WAIT && wait_q == fsp_pkg::CNT_W'(1) && !mrw_q) begin
				rd_data_q <= rd_s2_q;
			end
		end
	end

	assign link.ck = ck_q;
	assign link.cs = cs_q;
	assign link.mrw = mrw_q;
	assign link.ma = ma_q;
	assign link.op = op_q;
endmodule
`default_nettype wire

// File: logic/fsp_pkg.sv
// Purpose: Shared constants and layouts for the frequency set-point link
// Assumes: aclk at 10 MHz; link clock made by the controller by division
// Notes: Switch and hold times are kept in ps or ck periods and turned into aclk cycles here
package fsp_pkg;
	localparam int CLK_PERIOD_PS = 100000;
	localparam int CK_DIV = 8;
	localparam int CK_HALF = CK_DIV / 2;
	localparam logic [2:0] CK_LAST = 3'h7;
	localparam logic [2:0] CK_FALL = 3'h4;
	localparam int SW_SHORT_PS = 200000;
	localparam int SW_MIDDLE_PS = 200000;
	localparam int SW_LONG_PS = 250000;
	localparam int CLK_HOLD_PS = 7500;
	localparam int CLK_HOLD_NCK = 4;
	localparam int SW_SHORT_CYC = (SW_SHORT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SW_MIDDLE_CYC = (SW_MIDDLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SW_LONG_CYC = (SW_LONG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLK_HOLD_A = (CLK_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLK_HOLD_B = CLK_HOLD_NCK * CK_DIV;
	localparam int CLK_HOLD_CYC = (CLK_HOLD_A > CLK_HOLD_B) ? CLK_HOLD_A : CLK_HOLD_B;
	localparam int RD_WAIT_CYC = 2 * CK_DIV;
	localparam int CMD_GAP_CYC = CK_DIV;
	localparam int CNT_W = 16;
	localparam int DUP_N = 7;
	localparam int IDX_CMD_ADDR_REFERENCE_CFG = 4;
	// Mode register addresses of the duplicated registers, index 0 last
	localparam logic [DUP_N-1:0][5:0] DUP_MA = {6'h16, 6'h0e, 6'h0c, 6'h0b, 6'h03, 6'h02, 6'h01};
	localparam logic [5:0] MA_SELECT = 6'h0d;
	localparam logic [7:0] DUP_RESET = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	// AXI4-Lite map of the controller
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CMD = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] STRB_ALL = 4'hf;

	typedef struct packed {
		logic read_postamble_long;
		logic [2:0] write_recovery_autoprecharge;
		logic read_preamble_type;
		logic write_preamble_long;
		logic [1:0] rsvd;
	} fsp_mr1_t;
	typedef struct packed {
		logic rsvd;
		logic write_latency_set_select;
		logic [2:0] write_latency;
		logic [2:0] read_latency;
	} fsp_mr2_t;
	typedef struct packed {
		logic write_bus_inversion_enable;
		logic read_bus_inversion_enable;
		logic [2:0] pulldown_drive_strength;
		logic rsvd;
		logic write_postamble_long;
		logic pullup_calibration_point;
	} fsp_mr3_t;
	typedef struct packed {
		logic rsvd_hi;
		logic [2:0] cmd_addr_termination;
		logic rsvd_lo;
		logic [2:0] data_termination;
	} fsp_termination_cfg_t;
	typedef struct packed {
		logic rsvd;
		logic range;
		logic [5:0] setting;
	} fsp_vref_t;
	typedef struct packed {
		logic [1:0] rsvd;
		logic cmd_addr_termination_disable;
		logic chip_select_termination_enable;
		logic clock_termination_enable;
		logic [2:0] controller_termination;
	} fsp_rank_termination_cfg_t;
	typedef struct packed {
		logic setpoint_operating_select;
		logic setpoint_access_select;
		logic [1:0] rsvd_hi;
		logic reference_generator_current_mode;
		logic [2:0] rsvd_lo;
	} fsp_set_point_select_ctrl_t;
	typedef struct packed {
		logic [14:0] rsvd;
		logic mrr;
		logic [1:0] rsvd_ma;
		logic [5:0] ma;
		logic [7:0] op;
	} fsp_cmd_t;

	// Switch time from the two command/address reference copies
	function automatic logic [CNT_W-1:0] fsp_switch_cycles(input fsp_vref_t a, input fsp_vref_t b);
		logic [5:0] diff;
		diff = (a.setting > b.setting) ? a.setting - b.setting : b.setting - a.setting;
		if (a.range != b.range) begin
			return CNT_W'(SW_LONG_CYC);
		end else if (diff > 6'h01) begin
			return CNT_W'(SW_MIDDLE_CYC);
		end
		return CNT_W'(SW_SHORT_CYC);
	endfunction
endpackage

// File: logic/fsp_link_if.sv
// Purpose: Mode register command link between controller and DRAM end
// Assumes: ck is made by the controller; cs changes while it is low, mrw, ma and op at command start, read data after its rise
// Notes: Read data is held by the DRAM end until the next read
`timescale 1ns/100ps
`default_nettype none
interface fsp_link_if;
	logic ck;
	logic cs;
	logic mrw;
	logic [5:0] ma;
	logic [7:0] op;
	logic [7:0] mrr_data;
	modport ctrl (output ck, output cs, output mrw, output ma, output op, input mrr_data);
	modport dram (input ck, input cs, input mrw, input ma, input op, output mrr_data);
endinterface
`default_nettype wire

// File: logic/fsp_reg_pair.sv
// Purpose: Two physical copies of one mode register behind one address
// Assumes: Write and select inputs are on the aclk domain
// Notes: active_q follows the operating copy one cycle later
`timescale 1ns/100ps
`default_nettype none
module fsp_reg_pair #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic wr_copy,
	input wire logic [7:0] wr_data,
	input wire logic op_copy,
	output logic [1:0][7:0] copy_q,
	output logic [7:0] active_q
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			copy_q <= {RESET_VAL, RESET_VAL};
		end else if (wr_en) begin
			copy_q[wr_copy] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_q <= RESET_VAL;
		end else begin
			active_q <= copy_q[op_copy];
		end
	end
endmodule
`default_nettype wire

// File: logic/fsp_dram_end.sv
// Purpose: DRAM end of the set-point logic: duplicated mode registers
// Assumes: Link pins are asynchronous to aclk and pass two flip-flops
// Notes: Commands are taken at the synchronised rising edge of ck
`timescale 1ns/100ps
`default_nettype none
// Contract
// R01 - Two copies per parameter, one shared address
// R02 - Access select bit 6 steers writes, reads
// R03 - Operating select bit 7 picks active copy
// R04 - Writes to other copy leave operation alone
// R05 - Operating toggle adopts all parameters within time
// R06 - Both select bits act fully independently
// R07 - Register 1 preamble, recovery, postamble duplicated
// R08 - Register 2 latencies and set select duplicated
// R09 - Register 3 drive, calibration, inversion duplicated
// R10 - Register 11 bus terminations duplicated
// R11 - Reference settings and ranges duplicated
// R12 - Register 22 termination controls duplicated
// R13 - Controller sets equal pull-up calibration point; controller end passes register 3 writes unchanged
// R14 - Controller sets fast reference mode when switching
// R15 - Controller waits 200 ns, single step
// R16 - Controller waits 200 ns, multi step
// R17 - Controller waits 250 ns, range change
// R18 - Clock stays valid after switch command
// R19 - Clock valid before first command after switch
// R20 - Same time choice in both directions
// R21 - Switch with one write, then wait
// R22 - Only deselect until switch time elapsed
module fsp_dram_end (
	input wire logic aclk,
	input wire logic aresetn,
	fsp_link_if.dram link,
	output fsp_pkg::fsp_mr1_t preamble_postamble_recovery_cfg,
	output fsp_pkg::fsp_mr2_t latency_cfg,
	output fsp_pkg::fsp_mr3_t drive_inversion_cfg,
	output fsp_pkg::fsp_termination_cfg_t termination_cfg,
	output fsp_pkg::fsp_vref_t cmd_addr_reference_cfg,
	output fsp_pkg::fsp_vref_t data_reference_cfg,
	output fsp_pkg::fsp_rank_termination_cfg_t rank_termination_cfg,
	output logic setpoint_operating_select,
	output logic setpoint_access_select,
	output logic reference_generator_current_mode,
	output logic switch_busy
);
	logic ck_s1_q;
	logic ck_s2_q;
	logic ck_s3_q;
	logic cs_s1_q;
	logic cs_s2_q;
	logic mrw_s1_q;
	logic mrw_s2_q;
	logic [5:0] ma_s1_q;
	logic [5:0] ma_s2_q;
	logic [7:0] op_s1_q;
	logic [7:0] op_s2_q;
	logic ck_rise;
	logic cmd_take;
	logic sel_wr;
	fsp_pkg::fsp_set_point_select_ctrl_t select_q;
	fsp_pkg::fsp_set_point_select_ctrl_t select_new;
	logic [fsp_pkg::DUP_N-1:0][1:0][7:0] copies;
	logic [fsp_pkg::DUP_N-1:0][7:0] active;
	logic [fsp_pkg::DUP_N-1:0] dup_hit;
	logic [7:0] rd_value;
	logic [7:0] mrr_data_q;
	logic [fsp_pkg::CNT_W-1:0] busy_cnt_q;
	logic switch_start;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
			cs_s1_q <= 1'b0;
			cs_s2_q <= 1'b0;
			mrw_s1_q <= 1'b0;
			mrw_s2_q <= 1'b0;
			ma_s1_q <= 6'h00;
			ma_s2_q <= 6'h00;
			op_s1_q <= 8'h00;
			op_s2_q <= 8'h00;
		end else begin
			ck_s1_q <= link.ck;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
			cs_s1_q <= link.cs;
			cs_s2_q <= cs_s1_q;
			mrw_s1_q <= link.mrw;
			mrw_s2_q <= mrw_s1_q;
			ma_s1_q <= link.ma;
			ma_s2_q <= ma_s1_q;
			op_s1_q <= link.op;
			op_s2_q <= op_s1_q;
		end
	end

	assign ck_rise = ck_s2_q && !ck_s3_q;
	assign cmd_take = ck_rise && cs_s2_q;
	assign sel_wr = cmd_take && mrw_s2_q && (ma_s2_q == fsp_pkg::MA_SELECT);
	assign select_new = fsp_pkg::fsp_set_point_select_ctrl_t'(op_s2_q);

	// Select register: access and operating bits stored side by side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			select_q <= fsp_pkg::fsp_set_point_select_ctrl_t'(fsp_pkg::SELECT_RESET);
		end else if (sel_wr) begin
			select_q <= select_new; // R06
		end
	end

	// One copy pair per duplicated register
	genvar gi;
	generate
		for (gi = 0; gi < fsp_pkg::DUP_N; gi++) begin : g_dup
			assign dup_hit[gi] = (ma_s2_q == fsp_pkg::DUP_MA[gi]);
			fsp_reg_pair #(
				.RESET_VAL(fsp_pkg::DUP_RESET)
			) u_pair (
				.aclk(aclk),
				.aresetn(aresetn),
				.wr_en(cmd_take && mrw_s2_q && dup_hit[gi]), // R01 R04
				.wr_copy(select_q.setpoint_access_select), // R02
				.wr_data(op_s2_q),
				.op_copy(select_q.setpoint_operating_select), // R03 R05
				.copy_q(copies[gi]),
				.active_q(active[gi])
			);
		end
	endgenerate

	// Read path follows the access select only
	always_comb begin
		rd_value = 8'h00;
		for (int i = 0; i < fsp_pkg::DUP_N; i++) begin
			if (dup_hit[i]) begin
				rd_value = copies[i][select_q.setpoint_access_select]; // R02 R06
			end
		end
		if (ma_s2_q == fsp_pkg::MA_SELECT) begin
			rd_value = select_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mrr_data_q <= 8'h00;
		end else if (cmd_take && !mrw_s2_q) begin
			mrr_data_q <= rd_value;
		end
	end

	assign link.mrr_data = mrr_data_q;

	// Switch time from the two reference copies, either direction
	assign switch_start = sel_wr &&
		(select_new.setpoint_operating_select != select_q.setpoint_operating_select);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt_q <= '0;
		end else if (switch_start) begin
			busy_cnt_q <= fsp_pkg::fsp_switch_cycles(copies[fsp_pkg::IDX_CMD_ADDR_REFERENCE_CFG][0],
				copies[fsp_pkg::IDX_CMD_ADDR_REFERENCE_CFG][1]); // R05
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
		end
	end

	assign switch_busy = (busy_cnt_q != '0);

	// Active parameters, every field from the operating copy
	assign preamble_postamble_recovery_cfg = fsp_pkg::fsp_mr1_t'(active[0]); // R07
	assign latency_cfg = fsp_pkg::fsp_mr2_t'(active[1]); // R08
	assign drive_inversion_cfg = fsp_pkg::fsp_mr3_t'(active[2]); // R09
	assign termination_cfg = fsp_pkg::fsp_termination_cfg_t'(active[3]); // R10
	assign cmd_addr_reference_cfg = fsp_pkg::fsp_vref_t'(active[4]); // R11
	assign data_reference_cfg = fsp_pkg::fsp_vref_t'(active[5]); // R11
	assign rank_termination_cfg = fsp_pkg::fsp_rank_termination_cfg_t'(active[6]); // R12
	assign setpoint_operating_select = select_q.setpoint_operating_select;
	assign setpoint_access_select = select_q.setpoint_access_select;
	assign reference_generator_current_mode = select_q.reference_generator_current_mode;
endmodule
`default_nettype wire

// File: test/fsp_assertions.sv
// Purpose: Concurrent checks on the set-point command link
// Assumes: Link sampled on aclk; ck made by aclk division
// Notes: Spacing after a switch counted in idle select cycles
`timescale 1ns/100ps
`default_nettype none
module fsp_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ck,
	input wire logic cs,
	input wire logic mrw,
	input wire logic [5:0] ma,
	input wire logic [7:0] op,
	input wire logic [7:0] mrr_data
);
	localparam int GAP_MIN = fsp_pkg::CLK_HOLD_CYC + fsp_pkg::SW_SHORT_CYC;
	logic cs_q;
	logic [4:0] cnt_q;
	logic sel_q;
	logic pend_q;
	logic [7:0] gap_q;
	logic [4:0] rd_q;
	logic warm;
	logic new_cmd;
	logic sel_wr;
	assign warm = (cnt_q == 5'h1f);
	assign new_cmd = cs && !cs_q;
	assign sel_wr = new_cmd && mrw && (ma == fsp_pkg::MA_SELECT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs_q <= 1'b0;
			cnt_q <= 5'h00;
		end else begin
			cs_q <= cs;
			cnt_q <= warm ? cnt_q : cnt_q + 5'h01;
		end
	end
	// Operating copy as last written, and idle span since a switch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= 1'b0;
			pend_q <= 1'b0;
			gap_q <= 8'h00;
		end else if (new_cmd) begin
			pend_q <= sel_wr && (op[7] != sel_q);
			gap_q <= 8'h00;
			sel_q <= sel_wr ? op[7] : sel_q;
		end else if (!cs && gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= 5'h00;
		end else if (new_cmd && !mrw) begin
			rd_q <= 5'h14;
		end else if (rd_q != 5'h00) begin
			rd_q <= rd_q - 5'h01;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_ck_high_span: assert property (warm && $rose(ck) |-> ck[*4] ##1 !ck)
		else $error("link clock high phase wrong");
	a_ck_low_span: assert property (warm && $fell(ck) |-> !ck[*4] ##1 ck)
		else $error("link clock low phase wrong");
	a_cs_launch_low: assert property ($rose(cs) |-> !ck)
		else $error("select raised while clock high");
	a_cs_one_period: assert property ($rose(cs) |-> cs[*8] ##1 !cs)
		else $error("select not one clock period");
	a_cmd_held: assert property (cs && $past(cs) |-> $stable({mrw, ma, op}))
		else $error("command changed under select");
	a_switch_fast_ref: assert property (sel_wr && (op[7] != sel_q) |-> op[3])
		else $error("switch without fast reference mode");
	a_switch_gap_kept: assert property (new_cmd && pend_q |-> gap_q >= GAP_MIN)
		else $error("command too soon after switch");
	a_read_data_held: assert property (warm && !$stable(mrr_data) |-> rd_q != 5'h00)
		else $error("read data changed without read");
	c_switch: cover property (sel_wr && (op[7] != sel_q));
	c_read: cover property (new_cmd && !mrw);
	c_ref_write: cover property (new_cmd && mrw && ma == fsp_pkg::DUP_MA[fsp_pkg::IDX_CMD_ADDR_REFERENCE_CFG]);
endmodule
`default_nettype wire

// File: test/dram_frequency_set_point_regs_tb.sv
// Purpose: Bench for controller and DRAM set-point ends joined by the link
// Assumes: aclk 10 MHz; both ends share clock and reset
// Notes: Copy contents random from a fixed seed; switch corners forced
`timescale 1ns/100ps
`default_nettype none
module dram_frequency_set_point_regs_tb;
	localparam logic [6:0][7:0] MASK = {8'h3f, 8'h7f, 8'h7f, 8'h77, 8'hfb, 8'h7f, 8'hfc};
	logic aclk, aresetn, op_sel, acc_sel, rgc, sw_busy;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	wire [6:0][7:0] cfg;
	logic [7:0] v [2][7];
	int n_errors = 0;
	int total_checks = 0;
	int run_len = 0;
	int last_len = 0;
	int seed = 32'h05ae2327;
	fsp_link_if link ();
	fsp_dram_end fsp_dram_end_i (.aclk, .aresetn, .link(link), .preamble_postamble_recovery_cfg(cfg[0]),
		.latency_cfg(cfg[1]), .drive_inversion_cfg(cfg[2]), .termination_cfg(cfg[3]),
		.cmd_addr_reference_cfg(cfg[4]), .data_reference_cfg(cfg[5]), .rank_termination_cfg(cfg[6]),
		.setpoint_operating_select(op_sel), .setpoint_access_select(acc_sel),
		.reference_generator_current_mode(rgc), .switch_busy(sw_busy));
	fsp_ctrl_end fsp_ctrl_end_i (.aclk, .aresetn, .link(link), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	fsp_assertions fsp_assertions_i (.aclk, .aresetn, .ck(link.ck), .cs(link.cs), .mrw(link.mrw),
		.ma(link.ma), .op(link.op), .mrr_data(link.mrr_data));
	always #50 aclk = ~aclk;
	// Length of each switch busy pulse
	always @(posedge aclk) begin
		if (sw_busy === 1'b1) begin
			run_len <= run_len + 1;
		end else if (run_len != 0) begin
			last_len <= run_len;
			run_len <= 0;
		end
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	// Mode register command, then wait until the controller is idle
	task automatic mr_cmd(input logic rd, input logic [5:0] ma, input logic [7:0] op, output logic [31:0] st);
		logic [1:0] rsp;
		axi_wr(fsp_pkg::OFS_CMD, {15'h0000, rd, 2'h0, ma, op}, fsp_pkg::STRB_ALL, rsp);
		do begin
			axi_rd(fsp_pkg::OFS_STATUS, st, rsp);
		end while (st[0] !== 1'b0);
	endtask
	function automatic int exp_len(input logic [7:0] a, input logic [7:0] b);
		if (a[6] != b[6]) return fsp_pkg::SW_LONG_CYC;
		if (((a[5:0] > b[5:0]) ? a[5:0] - b[5:0] : b[5:0] - a[5:0]) > 6'h01) return fsp_pkg::SW_MIDDLE_CYC;
		return fsp_pkg::SW_SHORT_CYC;
	endfunction
	task stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		stop_test();
	end
	initial begin
		logic cur, alt;
		logic [1:0] rsp;
		logic [31:0] st;
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
		cur = 1'b0;
		for (int i = 0; i < 7; i++) v[0][i] = 8'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("cfg_reset", cfg, 64'h0);
		chk("sel_reset", {op_sel, acc_sel, rgc}, 3'h0);
		$display("test reset done");
		for (int r = 0; r < 5; r++) begin
			alt = ~cur;
			mr_cmd(1'b0, fsp_pkg::MA_SELECT, {cur, alt, 6'h00}, st);
			for (int i = 0; i < 7; i++) v[alt][i] = 8'($random(seed));
			if (r < 3) v[alt][4] = {1'b0, v[cur][4][6] ^ (r == 2), v[cur][4][5:0] ^ ((r == 0) ? 6'h01 : 6'h02)};
			for (int i = 0; i < 7; i++) begin
				mr_cmd(1'b0, fsp_pkg::DUP_MA[i], v[alt][i], st);
				chk("active_kept", cfg[i] & MASK[i], v[cur][i] & MASK[i]);
				mr_cmd(1'b1, fsp_pkg::DUP_MA[i], 8'h00, st);
				chk("read_alt", st[15:8] & MASK[i], v[alt][i] & MASK[i]);
			end
			mr_cmd(1'b0, fsp_pkg::MA_SELECT, {alt, cur, 6'h00}, st);
			chk("fast_ref", rgc, 1'b1);
			chk("shadow", st[23:16], {alt, cur, 6'h08});
			chk("selects", {op_sel, acc_sel}, {alt, cur});
			chk("busy_len", last_len, exp_len(v[cur][4], v[alt][4]));
			for (int i = 0; i < 7; i++) begin
				chk("active_new", cfg[i] & MASK[i], v[alt][i] & MASK[i]);
				mr_cmd(1'b1, fsp_pkg::DUP_MA[i], 8'h00, st);
				chk("read_cur", st[15:8] & MASK[i], v[cur][i] & MASK[i]);
			end
			mr_cmd(1'b0, fsp_pkg::MA_SELECT, {alt, cur, 6'h00}, st);
			chk("fast_ref_off", {rgc, op_sel}, {1'b0, alt});
			cur = alt;
			$display("test round %0d done", r);
		end
		axi_wr(4'h8, 32'h0, fsp_pkg::STRB_ALL, rsp);
		chk("wr_unmapped", rsp, fsp_pkg::RESP_SLVERR);
		axi_rd(4'hc, st, rsp);
		chk("rd_unmapped", {rsp, st}, {fsp_pkg::RESP_SLVERR, 32'h0});
		axi_rd(fsp_pkg::OFS_CMD, st, rsp);
		chk("cmd_read", {rsp, st}, {fsp_pkg::RESP_OKAY, 32'h0});
		alt = ~cur;
		mr_cmd(1'b1, fsp_pkg::MA_SELECT, 8'h00, st);
		chk("sel_read", st[15:8], {cur, alt, 6'h00});
		// Partial strobe: the accessed copy must keep its value
		axi_wr(fsp_pkg::OFS_CMD, {18'h0, fsp_pkg::DUP_MA[0], ~v[alt][0]}, 4'h3, rsp);
		mr_cmd(1'b1, fsp_pkg::DUP_MA[0], 8'h00, st);
		chk("strb_drop", {rsp, cfg[0], st[15:8]}, {fsp_pkg::RESP_OKAY, v[cur][0], v[alt][0]});
		// Command written while the controller is busy is dropped
		axi_wr(fsp_pkg::OFS_CMD, {16'h0001, 2'h0, fsp_pkg::DUP_MA[0], 8'h00}, fsp_pkg::STRB_ALL, rsp);
		axi_wr(fsp_pkg::OFS_CMD, {18'h0, fsp_pkg::DUP_MA[0], ~v[alt][0]}, fsp_pkg::STRB_ALL, rsp);
		chk("busy_resp", rsp, fsp_pkg::RESP_OKAY);
		do begin
			axi_rd(fsp_pkg::OFS_STATUS, st, rsp);
		end while (st[0] !== 1'b0);
		mr_cmd(1'b1, fsp_pkg::DUP_MA[0], 8'h00, st);
		chk("busy_drop", {cfg[0], st[15:8]}, {v[cur][0], v[alt][0]});
		mr_cmd(1'b1, 6'h05, 8'h00, st);
		chk("unknown_ma", st[15:8], 8'h00);
		$display("test errors done");
		stop_test();
	end
endmodule
`default_nettype wire
